// ---- csrb_bank.sv ----
`default_nettype none
module csrb_bank #(
   parameter int DEXT_BITS = 8,
   parameter int XEXT_BITS = 8,
   parameter int YEXT_BITS = 8,
   parameter int ZEXT_BITS = 8,
   parameter int JEXT_BITS = 8,
   parameter int STK_BITS = 16,
   parameter logic [15:0] STK_TOP = csrb_pkg::STK_RST
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // I/O space access
   input wire csrb_pkg::csrb_io_t io,
   output logic [7:0] rdata,
   // Core events
   input wire csrb_pkg::csrb_core_t core,
   input wire logic irqTake,
   // Address operands
   input wire logic [15:0] directOp,
   input wire logic [15:0] ptrX,
   input wire logic [15:0] ptrY,
   input wire logic [15:0] ptrZ,
   // Formed addresses
   output logic [23:0] directAddr,
   output logic [23:0] addrX,
   output logic [23:0] addrY,
   output logic [23:0] addrZ,
   output logic [23:0] pmAddr,
   output logic [23:0] jumpAddr,
   // Stack pointer, flags and status
   output logic [15:0] stackPtr,
   output logic [7:0] statusOut,
   output logic irqAllow,
   output logic ioUnlocked,
   output logic pmUnlocked
);
   // ==========================================
   // Storage
   logic [7:0] dext_r, xext_r, yext_r, zext_r, jext_r;
   logic [15:0] stk_r;
   logic [7:0] stkTemp_r;
   logic [7:0] flags_r;
   logic ioOpen, pmOpen, keyWr, cpuWr;

   function automatic logic [7:0] trim(input logic [7:0] v, input int n);
      trim = v & 8'((9'h001 << n) - 9'h001);
   endfunction
   function automatic logic hit(input csrb_pkg::csrb_io_t a,
                                input logic [3:0] ofs);
      hit = a.wr && !a.dma && a.addr == ofs;
   endfunction

   assign cpuWr = io.wr && !io.dma;
   assign keyWr = hit(io, csrb_pkg::OFS_KEY);

   csrb_unlock u_unlock (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .keyWr(keyWr),
      .keyVal(io.wdata),
      .retire(core.retire),
      // Non-DMA writes other than the key close the I/O window
      .ioClose((cpuWr && !keyWr) || core.dataWr || core.pmInstr
               || core.sleepInstr),
      .pmClose(core.dataWr || core.sleepInstr),
      .ioOpen(ioOpen),
      .pmOpen(pmOpen)
   );

   // ==========================================
   // Extension registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dext_r <= csrb_pkg::EXT_RST;
         xext_r <= csrb_pkg::EXT_RST;
         yext_r <= csrb_pkg::EXT_RST;
         zext_r <= csrb_pkg::EXT_RST;
         jext_r <= csrb_pkg::EXT_RST;
      end else begin
         if (hit(io, csrb_pkg::OFS_DEXT)) begin
            dext_r <= trim(io.wdata, DEXT_BITS);
         end
         if (hit(io, csrb_pkg::OFS_XEXT)) begin
            xext_r <= trim(io.wdata, XEXT_BITS);
         end
         if (hit(io, csrb_pkg::OFS_YEXT)) begin
            yext_r <= trim(io.wdata, YEXT_BITS);
         end
         if (hit(io, csrb_pkg::OFS_ZEXT)) begin
            zext_r <= trim(io.wdata, ZEXT_BITS);
         end
         if (hit(io, csrb_pkg::OFS_JEXT)) begin
            jext_r <= trim(io.wdata, JEXT_BITS);
         end
      end
   end

   // ==========================================
   // Stack pointer, low byte parked until high byte
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stk_r <= STK_TOP;
         stkTemp_r <= 8'h00;
      end else begin
         if (hit(io, csrb_pkg::OFS_STKLO)) begin
            stkTemp_r <= io.wdata;
         end
         if (hit(io, csrb_pkg::OFS_STKHI)) begin
            // Both bytes land together so the stack never sees a torn value
            stk_r <= {io.wdata, stkTemp_r} &
                     16'((17'h00001 << STK_BITS) - 17'h00001);
         end
      end
   end

   // ==========================================
   // Status flags
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         flags_r <= csrb_pkg::FLAGS_RST;
      end else if (hit(io, csrb_pkg::OFS_FLAGS)) begin
         flags_r <= io.wdata;
         flags_r[csrb_pkg::BIT_S] <= io.wdata[csrb_pkg::BIT_N]
                                     ^ io.wdata[csrb_pkg::BIT_V];
      end else begin
         // Interrupt entry leaves the global enable alone
         if (core.irqSet) begin
            flags_r[csrb_pkg::BIT_I] <= 1'b1;
         end else if (core.irqClr) begin
            flags_r[csrb_pkg::BIT_I] <= 1'b0;
         end
         if (core.bitStore) begin
            flags_r[csrb_pkg::BIT_T] <= core.bitIn;
         end
         if (core.flagWe) begin
            flags_r[csrb_pkg::BIT_H] <= core.flagVal[3];
            flags_r[csrb_pkg::BIT_V] <= core.flagVal[2];
            flags_r[csrb_pkg::BIT_N] <= core.flagVal[1];
            flags_r[csrb_pkg::BIT_S] <= core.flagVal[1]
                                        ^ core.flagVal[2];
            if (core.flagMask[1]) begin
               flags_r[csrb_pkg::BIT_Z] <= core.flagVal[0];
            end
            if (core.flagMask[0]) begin
               flags_r[csrb_pkg::BIT_C] <= core.flagMask[3];
            end
         end
      end
   end

   // ==========================================
   // Read mux
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else if (io.rd) begin
         unique case (io.addr)
            csrb_pkg::OFS_KEY: begin
               rdata <= {6'h00, pmOpen, ioOpen};
            end
            csrb_pkg::OFS_DEXT: rdata <= dext_r;
            csrb_pkg::OFS_XEXT: rdata <= xext_r;
            csrb_pkg::OFS_YEXT: rdata <= yext_r;
            csrb_pkg::OFS_ZEXT: rdata <= zext_r;
            csrb_pkg::OFS_JEXT: rdata <= jext_r;
            csrb_pkg::OFS_STKLO: rdata <= stk_r[7:0];
            csrb_pkg::OFS_STKHI: rdata <= stk_r[15:8];
            csrb_pkg::OFS_FLAGS: rdata <= flags_r;
            default: rdata <= 8'h00;
         endcase
      end
   end

   // ==========================================
   // Address formation and status outputs
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         directAddr <= 24'h000000;
         addrX <= 24'h000000;
         addrY <= 24'h000000;
         addrZ <= 24'h000000;
         pmAddr <= 24'h000000;
         jumpAddr <= 24'h000000;
      end else begin
         // Below 64K the extension is simply zero-weighted by the user
         directAddr <= {dext_r, directOp};
         addrX <= {xext_r, ptrX};
         addrY <= {yext_r, ptrY};
         addrZ <= {zext_r, ptrZ};
         pmAddr <= {zext_r, ptrZ};
         jumpAddr <= {jext_r, ptrZ};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stackPtr <= STK_TOP;
         statusOut <= csrb_pkg::FLAGS_RST;
         irqAllow <= 1'b0;
         ioUnlocked <= 1'b0;
         pmUnlocked <= 1'b0;
      end else begin
         stackPtr <= stk_r;
         statusOut <= flags_r;
         // Held requests stay pending in the controller; allow returns
         irqAllow <= flags_r[csrb_pkg::BIT_I] && !ioOpen && !pmOpen
                     && !irqTake;
         ioUnlocked <= ioOpen;
         pmUnlocked <= pmOpen;
      end
   end
endmodule
`default_nettype wire

// ---- csrb_bank_assertions.sv ----
`default_nettype none
module csrb_bank_assertions #(
   parameter logic [15:0] STK_TOP = csrb_pkg::STK_RST
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Watched ports
   input wire csrb_pkg::csrb_io_t io,
   input wire csrb_pkg::csrb_core_t core,
   input wire logic [7:0] rdata,
   input wire logic [15:0] directOp,
   input wire logic [15:0] ptrZ,
   input wire logic [23:0] directAddr,
   input wire logic [23:0] jumpAddr,
   input wire logic [15:0] stackPtr,
   input wire logic [7:0] statusOut,
   input wire logic irqAllow,
   input wire logic ioUnlocked,
   input wire logic pmUnlocked
);
   // ==========================================
   // Helpers
   // Retires seen while the I/O window is open; saturates so a stuck window cannot wrap
   logic [3:0] retCnt_r;
   logic keyWr;
   assign keyWr = io.wr && io.addr == csrb_pkg::OFS_KEY;
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !ioUnlocked) begin
         retCnt_r <= 4'h0;
      end else if (core.retire && retCnt_r != 4'hF) begin
         retCnt_r <= retCnt_r + 4'h1;
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // ==========================================
   // Properties
   chk_io_key_opens:
      assert property (keyWr && !io.dma && io.wdata == csrb_pkg::KEY_IO
         |-> ##2 ioUnlocked) else $error("I/O key did not open");
   chk_key_readback:
      assert property ($past(io.rd && io.addr == csrb_pkg::OFS_KEY)
         |-> rdata == {6'h00, pmUnlocked, ioUnlocked})
         else $error("Key readback wrong");
   chk_window_bound:
      assert property (ioUnlocked |-> retCnt_r <= 4'h4)
         else $error("Window open too long");
   chk_irq_held:
      assert property (ioUnlocked || pmUnlocked |-> !irqAllow)
         else $error("Interrupt allowed in window");
   chk_global_gate:
      assert property (!statusOut[csrb_pkg::BIT_I] |-> !irqAllow)
         else $error("Interrupt allowed with enable clear");
   chk_sign_flag:
      assert property (statusOut[4] == (statusOut[2] ^ statusOut[3]))
         else $error("Sign flag wrong");
   chk_direct_addr:
      assert property ($past(rst_n) |-> directAddr[15:0] == $past(directOp))
         else $error("Direct address low part wrong");
   chk_jump_addr:
      assert property ($past(rst_n) |-> jumpAddr[15:0] == $past(ptrZ))
         else $error("Jump address low part wrong");
   chk_sp_reset:
      assert property ($rose(rst_n) |-> stackPtr == STK_TOP)
         else $error("Stack pointer reset wrong");
   chk_dma_ignored:
      assert property (keyWr && io.dma && !ioUnlocked && !pmUnlocked
         |-> ##2 !ioUnlocked && !pmUnlocked) else $error("DMA key opened");
endmodule
bind csrb_bank csrb_bank_assertions #(.STK_TOP(STK_TOP)) u_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .io(io), .core(core), .rdata(rdata),
   .directOp(directOp), .ptrZ(ptrZ), .directAddr(directAddr),
   .jumpAddr(jumpAddr), .stackPtr(stackPtr), .statusOut(statusOut),
   .irqAllow(irqAllow), .ioUnlocked(ioUnlocked), .pmUnlocked(pmUnlocked)
);
`default_nettype wire

// ---- csrb_bank_tb_top.sv ----
`default_nettype none
module csrb_bank_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic w;
      logic [3:0] a;
      logic [7:0] v;
   } csrb_row_t;
   // Reset values, plain registers, flag store and refusals
   localparam csrb_row_t ROWS [14] = '{
      '{1'b0, 4'hE, 8'h3F}, '{1'b0, 4'hD, 8'hFF}, '{1'b0, 4'hF, 8'h00},
      '{1'b1, 4'h8, 8'hA5}, '{1'b1, 4'h9, 8'h11}, '{1'b1, 4'hA, 8'h22},
      '{1'b1, 4'hB, 8'h33}, '{1'b1, 4'hC, 8'h44}, '{1'b0, 4'h8, 8'hA5},
      '{1'b1, 4'hF, 8'h08}, '{1'b0, 4'hF, 8'h18}, '{1'b1, 4'hF, 8'h10},
      '{1'b0, 4'hF, 8'h00}, '{1'b1, 4'h2, 8'hFF}};
   logic clk_sys, rst_n, irqTake, irqAllow, ioUnlocked, pmUnlocked;
   csrb_pkg::csrb_io_t io;
   csrb_pkg::csrb_core_t core, ev;
   logic [15:0] directOp, ptrX, ptrY, ptrZ, stackPtr;
   logic [23:0] directAddr, addrX, addrY, addrZ, pmAddr, jumpAddr;
   logic [7:0] rdata, statusOut;
   int n_fail, comparisons;
   csrb_core_model core_m (.clk_sys(clk_sys), .io(io), .core(core));
   csrb_bank dut (.clk_sys(clk_sys), .rst_n(rst_n), .io(io), .rdata(rdata),
      .core(core), .irqTake(irqTake), .directOp(directOp), .ptrX(ptrX),
      .ptrY(ptrY), .ptrZ(ptrZ), .directAddr(directAddr), .addrX(addrX),
      .addrY(addrY), .addrZ(addrZ), .pmAddr(pmAddr), .jumpAddr(jumpAddr),
      .stackPtr(stackPtr), .statusOut(statusOut), .irqAllow(irqAllow),
      .ioUnlocked(ioUnlocked), .pmUnlocked(pmUnlocked));
   task automatic check(input string n, input logic [23:0] e,
      input logic [23:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic get(input logic [3:0] a, input logic [7:0] e);
      core_m.access(1'b0, 1'b0, a, 8'h00);
      check($sformatf("rdata_%h", a), {16'h0000, e}, {16'h0000, rdata});
   endtask
   task automatic put(input logic [3:0] a, input logic [7:0] d);
      core_m.access(1'b1, 1'b0, a, d);
   endtask
   task automatic conclude();
      if (n_fail == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // Whole run needs about a hundred cycles
   initial begin
      repeat (2000) @(posedge clk_sys);
      n_fail++;
      conclude();
   end
   initial begin
      {rst_n, irqTake, directOp, ptrX, ptrY, ptrZ} = '0;
      repeat (4) @(negedge clk_sys);
      rst_n = 1'b1;
      foreach (ROWS[i]) begin
         if (ROWS[i].w) begin
            put(ROWS[i].a, ROWS[i].v);
         end else begin
            get(ROWS[i].a, ROWS[i].v);
         end
      end
      get(4'h2, 8'h00);
      put(csrb_pkg::OFS_KEY, 8'h55);
      get(csrb_pkg::OFS_KEY, 8'h00);
      directOp = 16'h1234;
      ptrX = 16'h5678;
      ptrY = 16'h9ABC;
      ptrZ = 16'hDEF0;
      @(negedge clk_sys);
      check("directAddr", 24'hA51234, directAddr);
      check("addrX", 24'h115678, addrX);
      check("addrY", 24'h229ABC, addrY);
      check("addrZ", 24'h33DEF0, addrZ);
      check("pmAddr", 24'h33DEF0, pmAddr);
      check("jumpAddr", 24'h44DEF0, jumpAddr);
      put(csrb_pkg::OFS_STKLO, 8'h34);
      get(csrb_pkg::OFS_STKLO, 8'hFF);
      put(csrb_pkg::OFS_STKHI, 8'h12);
      @(negedge clk_sys);
      check("stackPtr", 24'h001234, {8'h00, stackPtr});
      ev = '0;
      ev.irqSet = 1'b1;
      core_m.pulse(ev);
      put(csrb_pkg::OFS_KEY, csrb_pkg::KEY_IO);
      get(csrb_pkg::OFS_KEY, 8'h01);
      check("ioUnlocked", 24'h1, {23'h0, ioUnlocked});
      check("irqAllow", 24'h0, {23'h0, irqAllow});
      ev = '0;
      ev.retire = 1'b1;
      repeat (3) core_m.pulse(ev);
      get(csrb_pkg::OFS_KEY, 8'h01);
      core_m.pulse(ev);
      get(csrb_pkg::OFS_KEY, 8'h00);
      check("ioUnlocked", 24'h0, {23'h0, ioUnlocked});
      check("irqAllow", 24'h1, {23'h0, irqAllow});
      @(negedge clk_sys);
      irqTake = 1'b1;
      @(negedge clk_sys);
      irqTake = 1'b0;
      get(csrb_pkg::OFS_FLAGS, 8'h80);
      put(csrb_pkg::OFS_KEY, csrb_pkg::KEY_PM);
      get(csrb_pkg::OFS_KEY, 8'h02);
      check("pmUnlocked", 24'h1, {23'h0, pmUnlocked});
      ev = '0;
      ev.dataWr = 1'b1;
      core_m.pulse(ev);
      get(csrb_pkg::OFS_KEY, 8'h00);
      put(csrb_pkg::OFS_KEY, csrb_pkg::KEY_IO);
      put(csrb_pkg::OFS_DEXT, 8'hA5);
      get(csrb_pkg::OFS_KEY, 8'h00);
      core_m.access(1'b1, 1'b1, csrb_pkg::OFS_KEY, csrb_pkg::KEY_IO);
      get(csrb_pkg::OFS_KEY, 8'h00);
      ev = '0;
      ev.irqClr = 1'b1;
      ev.bitStore = 1'b1;
      ev.bitIn = 1'b1;
      core_m.pulse(ev);
      get(csrb_pkg::OFS_FLAGS, 8'h40);
      check("irqAllow", 24'h0, {23'h0, irqAllow});
      // Flag update: H=1 V=1 N=0 Z=1, carry value 1, Z and C enabled
      ev = '0;
      ev.flagWe = 1'b1;
      ev.flagVal = 4'hD;
      ev.flagMask = 4'hB;
      core_m.pulse(ev);
      get(csrb_pkg::OFS_FLAGS, 8'h7B);
      rst_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      check("stackPtr", 24'h003FFF, {8'h00, stackPtr});
      check("statusOut", 24'h0, {16'h0, statusOut});
      conclude();
   end
endmodule
`default_nettype wire

// ---- csrb_core_model.sv ----
`default_nettype none
module csrb_core_model (
   // Clock
   input wire logic clk_sys,
   // Requests toward the bank
   output var csrb_pkg::csrb_io_t io,
   output var csrb_pkg::csrb_core_t core
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      io = '0;
      core = '0;
   end
   // ==========================================
   // Access held over one rising edge; released address and data show inverse, strobes drop to zero
   task automatic access(input logic w, input logic dma,
      input logic [3:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      io = '{w, !w, dma, a, d};
      @(negedge clk_sys);
      io = '{1'b0, 1'b0, 1'b0, ~a, ~d};
   endtask
   // ==========================================
   // One-cycle core event
   task automatic pulse(input csrb_pkg::csrb_core_t c);
      @(negedge clk_sys);
      core = c;
      @(negedge clk_sys);
      core = '0;
   endtask
endmodule
`default_nettype wire

// ---- csrb_pkg.sv ----
`default_nettype none
package csrb_pkg;
   // ==========================================
   // Register offsets
   localparam logic [3:0] OFS_KEY = 4'h4;
   localparam logic [3:0] OFS_DEXT = 4'h8;
   localparam logic [3:0] OFS_XEXT = 4'h9;
   localparam logic [3:0] OFS_YEXT = 4'hA;
   localparam logic [3:0] OFS_ZEXT = 4'hB;
   localparam logic [3:0] OFS_JEXT = 4'hC;
   localparam logic [3:0] OFS_STKLO = 4'hD;
   localparam logic [3:0] OFS_STKHI = 4'hE;
   localparam logic [3:0] OFS_FLAGS = 4'hF;
   // ==========================================
   // Keys, fields, resets, timing
   localparam logic [7:0] KEY_IO = 8'hD8;
   localparam logic [7:0] KEY_PM = 8'h9D;
   localparam int BIT_KIO = 0;
   localparam int BIT_KPM = 1;
   localparam int BIT_I = 7;
   localparam int BIT_T = 6;
   localparam int BIT_H = 5;
   localparam int BIT_S = 4;
   localparam int BIT_V = 3;
   localparam int BIT_N = 2;
   localparam int BIT_Z = 1;
   localparam int BIT_C = 0;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] EXT_RST = 8'h00;
   localparam logic [15:0] STK_RST = 16'h3FFF;
   localparam logic [2:0] WIN_INSTR = 3'h4;
   // ==========================================
   // Carriers
   typedef struct packed {
      logic wr;
      logic rd;
      logic dma;
      logic [3:0] addr;
      logic [7:0] wdata;
   } csrb_io_t;
   typedef struct packed {
      logic retire;
      logic dataWr;
      logic pmInstr;
      logic sleepInstr;
      logic flagWe;
      logic [3:0] flagMask;
      logic [3:0] flagVal;
      logic bitStore;
      logic bitIn;
      logic irqSet;
      logic irqClr;
   } csrb_core_t;
endpackage
`default_nettype wire

// ---- csrb_unlock.sv ----
`default_nettype none
module csrb_unlock (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Key write and closing events
   input wire logic keyWr,
   input wire logic [7:0] keyVal,
   input wire logic retire,
   input wire logic ioClose,
   input wire logic pmClose,
   // Window state
   output logic ioOpen,
   output logic pmOpen
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_IO = 3'b010,
      ST_PM = 3'b100
   } csrb_win_t;
   csrb_win_t state_r, state_nxt;
   logic [2:0] cnt_r;
   // ==========================================
   // Window state machine
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (keyWr && keyVal == csrb_pkg::KEY_IO) begin
               state_nxt = ST_IO;
            end else if (keyWr && keyVal == csrb_pkg::KEY_PM) begin
               state_nxt = ST_PM;
            end
         end
         ST_IO: begin
            if (ioClose || (retire && cnt_r == 3'h1)) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_PM: begin
            if (pmClose || (retire && cnt_r == 3'h1)) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end
   // Counts only instructions retired after the key write
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cnt_r <= 3'h0;
      end else if (state_r == ST_IDLE) begin
         cnt_r <= csrb_pkg::WIN_INSTR;
      end else if (retire && cnt_r != 3'h0) begin
         cnt_r <= cnt_r - 3'h1;
      end
   end
   assign ioOpen = state_r == ST_IO;
   assign pmOpen = state_r == ST_PM;
endmodule
`default_nettype wire
